/* File: inc/kre_defines.svh */
// constants for the keypad register editor
// assumes inclusion by bare name from package and rtl files
`ifndef KRE_DEFINES_SVH
`define KRE_DEFINES_SVH
`define KRE_MENU_COUNT 4
`define KRE_MENU_W 2
`define KRE_REG_W 4
`define KRE_REGS_PER_MENU 16
`define KRE_DIGITS 6
`define KRE_CUR_W 3
`define KRE_VALUE_W 24
`define KRE_ACODE_W 7
`define KRE_VERSION_ID 32'h00c0ffee
`endif

/* File: inc/kre_pkg.sv */
// types for the keypad register editor
// assumes kre_defines.svh is on the include path
`include "kre_defines.svh"
package kre_pkg;
   typedef enum logic [1:0] {KRE_MENU_DATA, KRE_MENU_SETUP, KRE_MENU_ADJUST, KRE_MENU_TEST} kre_menu_t;
   typedef enum {KRE_ST_RUN, KRE_ST_MENU, KRE_ST_NAME, KRE_ST_VALUE} kre_state_t;
   typedef logic [`KRE_VALUE_W-1:0] kre_value_t;
endpackage : kre_pkg

/* File: rtl/kre_value_mem.sv */
// register value store, one bcd word per register, registered read
// assumes a single clock; write and read addresses are independent
`timescale 1ns/1ns
module kre_value_mem #(
   parameter int AW = 6,
   parameter int DW = 24
) (
   // clocking
   input wire logic clock,
   input wire logic clkEn,
   // write port
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [DW-1:0] wrData,
   // read port
   input wire logic [AW-1:0] rdAddr,
   output logic [DW-1:0] rdData
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // no reset on the array; contents come from the persistent store at boot
   always_ff @(posedge clock)
   begin
      if (clkEn)
      begin
         if (wrEn)
            mem[wrAddr] <= wrData;
         rdData <= mem[rdAddr];
      end
   end
endmodule : kre_value_mem

/* File: rtl/kre_keypad_editor.sv */
// operator panel: menu walk and digit editing on four keys and a slide switch
// assumes keys are debounced, synchronous one-cycle presses
`timescale 1ns/1ns
`include "kre_defines.svh"
module kre_keypad_editor #(
   parameter int REGS_PER_MENU = `KRE_REGS_PER_MENU
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic clkEn,
   // operator controls
   input wire logic editPosition,
   input wire logic keyDown,
   input wire logic keyUp,
   input wire logic keyExit,
   input wire logic keyEnter,
   // display
   output kre_pkg::kre_menu_t menuSel,
   output logic [`KRE_REG_W-1:0] regSel,
   output logic showVersion,
   output logic showValue,
   output logic digitHighlight,
   output logic [`KRE_CUR_W-1:0] cursorPos,
   output kre_pkg::kre_value_t dispValue,
   output logic [`KRE_ACODE_W-1:0] accessCode,
   // system
   output logic suspendOps,
   output logic serialAllowed,
   output logic nvWrite,
   output logic [`KRE_ACODE_W-1:0] nvCode,
   output kre_pkg::kre_value_t nvData
);
   import kre_pkg::*;

   typedef struct packed {
      kre_state_t st;
      kre_menu_t menu;
      logic [`KRE_REG_W-1:0] regIdx;
      logic [`KRE_CUR_W-1:0] cur;
      kre_value_t edit;
      logic loadPend;
      logic showVer;
      logic valShow;
      logic suspend;
      logic serOk;
      logic nvWr;
      logic [`KRE_ACODE_W-1:0] nvCodeQ;
      kre_value_t nvDataQ;
      logic [`KRE_ACODE_W-1:0] acode;
   } kre_state_s_t;

   kre_state_s_t s_r, s_nxt;
   kre_value_t memRd;
   logic memWr;

   // access code: menu in high bits, register index low (one per register)
   function automatic logic [`KRE_ACODE_W-1:0] codeOf(input kre_menu_t m, input logic [`KRE_REG_W-1:0] r);
      codeOf = {1'b0, m, r};
   endfunction : codeOf

   // one bcd nibble stepped with wrap, other nibbles kept
   function automatic kre_value_t stepDigit(input kre_value_t v, input logic [`KRE_CUR_W-1:0] c,
                                            input logic inc);
      kre_value_t o;
      logic [3:0] d;
      o = v;
      d = v[c*4 +: 4];
      if (inc)
         d = (d >= 4'h9) ? 4'h0 : d + 4'h1;
      else
         d = (d == 4'h0) ? 4'h9 : d - 4'h1;
      o[c*4 +: 4] = d;
      stepDigit = o;
   endfunction : stepDigit

   kre_value_mem #(
      .AW(`KRE_ACODE_W - 1),
      .DW(`KRE_VALUE_W)
   ) valueMem (
      .clock(clock),
      .clkEn(clkEn),
      .wrEn(memWr),
      .wrAddr(s_r.nvCodeQ[`KRE_ACODE_W-2:0]),
      .wrData(s_r.nvDataQ),
      .rdAddr(s_r.acode[`KRE_ACODE_W-2:0]),
      .rdData(memRd)
   );
   assign memWr = s_r.nvWr;

   // menu walk; keys are ignored outside the edit position
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.nvWr = 1'b0;
      s_nxt.loadPend = 1'b0;
      if (s_r.loadPend)
         s_nxt.edit = memRd;
      case (s_r.st)
         KRE_ST_RUN:
         begin
            if (editPosition)
               s_nxt.st = KRE_ST_MENU;
         end
         KRE_ST_MENU:
         begin
            if (keyDown)
               s_nxt.menu = kre_menu_t'(s_r.menu + 2'h1);
            else if (keyUp)
               s_nxt.menu = kre_menu_t'(s_r.menu - 2'h1);
            else if (keyEnter)
            begin
               s_nxt.st = KRE_ST_NAME;
               s_nxt.regIdx = '0;
            end
         end
         KRE_ST_NAME:
         begin
            if (keyDown)
               s_nxt.regIdx = (s_r.regIdx == `KRE_REG_W'(REGS_PER_MENU - 1)) ? '0 : s_r.regIdx + 1'b1;
            else if (keyUp)
               s_nxt.regIdx = (s_r.regIdx == '0) ? `KRE_REG_W'(REGS_PER_MENU - 1) : s_r.regIdx - 1'b1;
            else if (keyExit)
               s_nxt.st = KRE_ST_MENU;
            else if (keyEnter)
            begin
               s_nxt.st = KRE_ST_VALUE;
               s_nxt.cur = '0;
               s_nxt.loadPend = 1'b1;
            end
         end
         KRE_ST_VALUE:
         begin
            if (keyDown)
               s_nxt.edit = stepDigit(s_r.edit, s_r.cur, 1'b1);
            else if (keyUp)
               s_nxt.edit = stepDigit(s_r.edit, s_r.cur, 1'b0);
            else if (keyExit)
               s_nxt.cur = (s_r.cur == `KRE_CUR_W'(`KRE_DIGITS - 1)) ? '0 : s_r.cur + 1'b1;
            else if (keyEnter)
            begin
               s_nxt.st = KRE_ST_NAME;
               s_nxt.nvWr = 1'b1;
               s_nxt.nvCodeQ = s_r.acode;
               s_nxt.nvDataQ = s_r.edit;
            end
         end
         default:
            s_nxt.st = KRE_ST_RUN;
      endcase
      // outside the edit position every key is dropped, a pending load too, the edit word is kept, and the panel returns to run
      if (!editPosition)
      begin
         s_nxt = s_r;
         s_nxt.nvWr = 1'b0;
         s_nxt.loadPend = 1'b0;
         s_nxt.st = KRE_ST_RUN;
      end
      s_nxt.acode = codeOf(s_nxt.menu, s_nxt.regIdx);
      s_nxt.showVer = (s_nxt.st == KRE_ST_RUN);
      s_nxt.valShow = (s_nxt.st == KRE_ST_VALUE);
      s_nxt.suspend = (s_nxt.st != KRE_ST_RUN);
      s_nxt.serOk = (s_nxt.st == KRE_ST_RUN);
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
         s_r.st <= KRE_ST_RUN;
         s_r.showVer <= 1'b1;
         s_r.serOk <= 1'b1;
      end
      else if (clkEn)
         s_r <= s_nxt;
   end

   assign menuSel = s_r.menu;
   assign regSel = s_r.regIdx;
   assign showVersion = s_r.showVer;
   assign showValue = s_r.valShow;
   assign digitHighlight = s_r.valShow;
   assign cursorPos = s_r.cur;
   assign dispValue = s_r.edit;
   assign accessCode = s_r.acode;
   assign suspendOps = s_r.suspend;
   assign serialAllowed = s_r.serOk;
   assign nvWrite = s_r.nvWr;
   assign nvCode = s_r.nvCodeQ;
   assign nvData = s_r.nvDataQ;

   // run position: keys have no effect
   property p_runIgnore;
      @(posedge clock) disable iff (rst)
      (clkEn && !editPosition && $past(clkEn) && !$past(editPosition)) |-> $stable(s_r.menu) && showVersion;
   endproperty
   a_runIgnore: assert property (p_runIgnore) else $error("keys acted in run position");

   property p_serialGate;
      @(posedge clock) disable iff (rst) serialAllowed |-> !suspendOps;
   endproperty
   a_serialGate: assert property (p_serialGate) else $error("serial allowed while editing");

   property p_menuFwd;
      @(posedge clock) disable iff (rst)
      (clkEn && editPosition && s_r.st == KRE_ST_MENU && keyDown) |=> menuSel == kre_menu_t'($past(menuSel) + 2'h1);
   endproperty
   a_menuFwd: assert property (p_menuFwd) else $error("menu did not advance");

   property p_menuBack;
      @(posedge clock) disable iff (rst)
      (clkEn && editPosition && s_r.st == KRE_ST_MENU && !keyDown && keyUp)
      |=> menuSel == kre_menu_t'($past(menuSel) - 2'h1);
   endproperty
   a_menuBack: assert property (p_menuBack) else $error("menu did not go back");

   property p_cursorWrap;
      @(posedge clock) disable iff (rst)
      (clkEn && editPosition && showValue && !keyDown && !keyUp && keyExit
       && cursorPos == `KRE_CUR_W'(`KRE_DIGITS - 1)) |=> cursorPos == '0;
   endproperty
   a_cursorWrap: assert property (p_cursorWrap) else $error("cursor did not wrap");

   sequence s_storeKey;
      clkEn && editPosition && showValue && !keyDown && !keyUp && !keyExit && keyEnter;
   endsequence
   property p_store;
      @(posedge clock) disable iff (rst) s_storeKey |=> nvWrite && !showValue && nvData == $past(dispValue);
   endproperty
   a_store: assert property (p_store) else $error("enter did not store value");

   property p_code;
      @(posedge clock) disable iff (rst) accessCode == {1'b0, menuSel, regSel};
   endproperty
   a_code: assert property (p_code) else $error("access code mismatch");

   property p_resume;
      @(posedge clock) disable iff (rst) (clkEn && !editPosition) |=> showVersion && !suspendOps;
   endproperty
   a_resume: assert property (p_resume) else $error("no resume on run");

   property p_suspend;
      @(posedge clock) disable iff (rst) (clkEn && editPosition) |=> suspendOps && !serialAllowed;
   endproperty
   a_suspend: assert property (p_suspend) else $error("not suspended in edit");

   property p_digitWrap;
      @(posedge clock) disable iff (rst)
      (clkEn && editPosition && showValue && !s_r.loadPend && keyDown && dispValue[cursorPos*4 +: 4] == 4'h9)
      |=> dispValue[$past(cursorPos)*4 +: 4] == 4'h0;
   endproperty
   a_digitWrap: assert property (p_digitWrap) else $error("digit did not wrap");
endmodule : kre_keypad_editor

/* File: dv/kre_operator_model.sv */
// operator model: slide switch and four debounced push buttons
// assumes the panel samples on the rising edge of clock
`timescale 1ns/1ns
module kre_operator_model (
   // clocking
   input wire logic clock,
   // controls toward the panel
   output logic editPosition,
   output logic keyDown,
   output logic keyUp,
   output logic keyExit,
   output logic keyEnter
);
   initial
   begin
      editPosition = 1'b0;
      {keyDown, keyUp, keyExit, keyEnter} = 4'h0;
   end

   // one key held for exactly one edge; k: 0 down, 1 up, 2 exit, 3 enter
   task press(input int k);
      @(posedge clock);
      #1;
      {keyDown, keyUp, keyExit, keyEnter} = 4'h8 >> k;
      @(posedge clock);
      #1;
      {keyDown, keyUp, keyExit, keyEnter} = 4'h0;
   endtask : press

   // switch moves between edges, then settles for two edges
   task slide(input logic e);
      @(posedge clock);
      #1;
      editPosition = e;
      repeat (2) @(posedge clock);
      #1;
   endtask : slide
endmodule : kre_operator_model

/* File: dv/kre_keypad_editor_bench.sv */
// self-checking bench for the keypad register editor
// assumes the operator model drives switch and keys
`timescale 1ns/1ns
module kre_keypad_editor_bench;
   import kre_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic clkEn = 1'b1;
   wire editPosition, keyDown, keyUp, keyExit, keyEnter;
   wire [1:0] menuSel;
   wire [3:0] regSel;
   wire showVersion, showValue, digitHighlight, suspendOps, serialAllowed, nvWrite;
   wire [2:0] cursorPos;
   wire [23:0] dispValue, nvData;
   wire [6:0] accessCode, nvCode;
   int n_errors = 0;
   int check_count = 0;

   always #5 clock = ~clock;

   kre_operator_model i_op (.clock(clock), .editPosition(editPosition), .keyDown(keyDown),
      .keyUp(keyUp), .keyExit(keyExit), .keyEnter(keyEnter));

   kre_keypad_editor i_dut (.clock(clock), .rst(rst), .clkEn(clkEn), .editPosition(editPosition),
      .keyDown(keyDown), .keyUp(keyUp), .keyExit(keyExit), .keyEnter(keyEnter),
      .menuSel(menuSel), .regSel(regSel), .showVersion(showVersion), .showValue(showValue),
      .digitHighlight(digitHighlight), .cursorPos(cursorPos), .dispValue(dispValue),
      .accessCode(accessCode), .suspendOps(suspendOps), .serialAllowed(serialAllowed),
      .nvWrite(nvWrite), .nvCode(nvCode), .nvData(nvData));

   // persistent store contents at boot: a known word for setup register 1, so digit edits are checkable
   initial
      i_dut.valueMem.mem[6'h11] = 24'h120409;

   // one comparison, counted and reported
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task results;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results

   // keys in run position change nothing
   task run_ignores_keys;
      for (int k = 0; k < 4; k++)
      begin
         i_op.press(k);
         chk({showVersion, serialAllowed, suspendOps}, 3'h6);
         chk({menuSel, regSel, showValue}, 7'h00);
      end
   endtask : run_ignores_keys

   // edit position suspends, menu walks through four titles
   task menu_walk;
      i_op.slide(1'b1);
      chk({showVersion, serialAllowed, suspendOps}, 3'h1);
      for (int m = 1; m < 4; m++)
      begin
         i_op.press(0);
         chk(menuSel, m);
      end
      for (int m = 2; m >= 0; m--)
      begin
         i_op.press(1);
         chk(menuSel, m);
      end
      i_op.press(2);
      chk(menuSel, 2'h0);
   endtask : menu_walk

   // clock enable low freezes the panel, keys included
   task freeze_holds;
      clkEn = 1'b0;
      i_op.press(0);
      chk(menuSel, 2'h0);
      clkEn = 1'b1;
      i_op.press(0);
      chk(menuSel, 2'h1);
      i_op.press(1);
      chk(menuSel, 2'h0);
   endtask : freeze_holds

   // register list of setup menu, codes, exit back to titles
   task register_list;
      i_op.press(0);
      i_op.press(3);
      chk({menuSel, regSel, showValue}, 7'h20);
      chk(accessCode, 7'h10);
      i_op.press(0);
      chk({regSel, accessCode}, 11'h091);
      i_op.press(1);
      chk(regSel, 4'h0);
      i_op.press(0);
      i_op.press(2);
      i_op.press(3);
      chk({menuSel, regSel}, 6'h10);
      i_op.press(0);
   endtask : register_list

   // value edit: cursor wraps, enter stores and returns to name
   task value_store;
      i_op.press(3);
      chk({showValue, digitHighlight, cursorPos}, 5'h18);
      // stored word arrives one edge after the enter edge; keys wait two edges for it
      repeat (2) @(posedge clock);
      #1;
      chk(dispValue, 24'h120409);
      i_op.press(0);
      chk(dispValue, 24'h120400);
      i_op.press(1);
      chk(dispValue, 24'h120409);
      for (int c = 1; c < 7; c++)
      begin
         i_op.press(2);
         chk(cursorPos, c % 6);
      end
      i_op.press(2);
      i_op.press(1);
      chk(dispValue, 24'h120499);
      i_op.press(3);
      chk({nvWrite, nvCode, showValue}, 9'h122);
      chk(nvData, 24'h120499);
      @(posedge clock);
      #1;
      chk(nvWrite, 1'b0);
      // reopen the value: the stored word must come back from the store
      i_op.press(3);
      @(posedge clock);
      #1;
      chk(dispValue, 24'h120499);
   endtask : value_store

   // back to run shows version and reopens serial
   task back_to_run;
      i_op.slide(1'b0);
      chk({showVersion, serialAllowed, suspendOps}, 3'h6);
      i_op.press(0);
      chk({menuSel, showVersion}, 3'h3);
   endtask : back_to_run

   initial
   begin
      repeat (10) @(posedge clock);
      #1;
      rst = 1'b0;
      run_ignores_keys();
      menu_walk();
      freeze_holds();
      register_list();
      value_store();
      back_to_run();
      results();
   end

   // hang guard, far beyond the 92 or so cycles used
   initial
   begin
      #100000;
      n_errors++;
      results();
   end
endmodule : kre_keypad_editor_bench
